// ===== bench/cond_source.sv
// cond_source: stands for the monitored instrument states.
// assumes the bench sets requested levels; they reach the pins just after an edge.
`timescale 1ns/100ps
`default_nettype none
module cond_source
(
    // clock
    input  wire logic        clk,
    // requested levels
    input  wire logic [15:0] cond_req,
    input  wire logic [15:0] trans_req,
    // pins
    output var  logic [15:0] cond_out,
    output var  logic [15:0] trans_out
);
    initial
    begin
        cond_out  = 16'h0000;
        trans_out = 16'h0000;
    end
    // levels change only after an edge, like a real state source
    always @(posedge clk)
    begin
        cond_out  <= cond_req;
        trans_out <= trans_req;
    end
endmodule
`default_nettype wire

// ===== bench/test_status_filter.sv
// test_status_filter: command sequences with expected register values.
// assumes cond_source drives the monitored states.
`timescale 1ns/100ps
`default_nettype none
module test_status_filter
    import status_filter_pkg::*;
;
    logic        clk;
    logic        rstn;
    logic        cmd_valid;
    cmd_t        cmd;
    resp_t       resp;
    logic        summary;
    logic [15:0] cond;
    logic [15:0] trans;
    logic [15:0] cond_set;
    logic [15:0] trans_set;
    int          errors;
    int          compares;
    // bit 15 transient, bit 14 unused, the rest with a condition bit
    status_filter #(.IMPL_MASK(16'h3fff), .USED_MASK(16'hbfff)) DUT (.CLK(clk),
        .RSTN(rstn), .COND_IN(cond), .TRANSIENT_IN(trans), .CMD_VALID(cmd_valid),
        .CMD(cmd), .RESP(resp), .SUMMARY(summary));
    cond_source src (.clk(clk), .cond_req(cond_set), .trans_req(trans_set),
        .cond_out(cond), .trans_out(trans));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic close_out();
        if (errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk_w(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_b(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic send(input cmd_op_t op, input logic [15:0] d);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd       <= '{op: op, data: d};
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask
    // answer stands in the cycle right after the taking edge
    task automatic rd(input cmd_op_t op, input logic [15:0] e, input string nm);
        send(op, 16'h0000);
        #1;
        chk_b("resp valid", 1'b1, resp.valid);
        chk_w(nm, e, resp.data);
    endtask
    // condition path needs three edges; five leaves margin
    task automatic setc(input logic [15:0] v);
        cond_set <= v;
        repeat (5) @(posedge clk);
    endtask
    task automatic sum_is(input logic e);
        repeat (2) @(posedge clk);
        #1;
        chk_b("summary", e, summary);
    endtask
    initial
    begin
        #500000;
        errors++;
        close_out();
    end
    initial
    begin
        errors = 0;
        compares = 0;
        rstn = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        cond_set = 16'h0000;
        trans_set = 16'h0000;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rd(OP_READ_RISE, 16'hffff, "rise");
        rd(OP_READ_FALL, 16'h0000, "fall");
        rd(OP_READ_ENABLE, 16'h0000, "enable");
        rd(OP_READ_EVENT, 16'h0000, "event");
        setc(16'hffff);
        rd(OP_READ_COND, 16'h3fff, "cond");
        rd(OP_READ_EVENT, 16'h3fff, "event");
        rd(OP_READ_EVENT, 16'h0000, "event");
        send(OP_WRITE_RISE, 16'h00ff);
        #1;
        chk_b("resp valid", 1'b0, resp.valid);
        send(OP_WRITE_FALL, 16'h0f0f);
        rd(OP_READ_RISE, 16'h00ff, "rise");
        rd(OP_READ_FALL, 16'h0f0f, "fall");
        setc(16'h1234);
        rd(OP_READ_COND, 16'h1234, "cond");
        rd(OP_READ_EVENT, 16'h0d0b, "event");
        setc(16'h0000);
        rd(OP_READ_EVENT, 16'h0204, "event");
        setc(16'hffff);
        setc(16'h0000);
        setc(16'hffff);
        send(OP_WRITE_ENABLE, 16'hf000);
        sum_is(1'b0);
        send(OP_WRITE_ENABLE, 16'hffff);
        sum_is(1'b1);
        rd(OP_READ_ENABLE, 16'hbfff, "enable");
        rd(OP_READ_EVENT, 16'h0fff, "event");
        setc(16'h0000);
        send(OP_CLEAR_STATUS, 16'h0000);
        sum_is(1'b0);
        rd(OP_READ_EVENT, 16'h0000, "event");
        rd(OP_READ_RISE, 16'h00ff, "rise");
        rd(OP_READ_ENABLE, 16'hbfff, "enable");
        trans_set <= 16'hc000;
        setc(16'h0000);
        trans_set <= 16'h0000;
        setc(16'h0000);
        rd(OP_READ_EVENT, 16'h8000, "event");
        send(OP_RESET_CMD, 16'h0000);
        rd(OP_READ_RISE, 16'hffff, "rise");
        rd(OP_READ_FALL, 16'h0000, "fall");
        // time the read so its clear meets the passed rising edges
        cond_set <= 16'hffff;
        repeat (2) @(posedge clk);
        rd(OP_READ_EVENT, 16'h0000, "event");
        rd(OP_READ_EVENT, 16'h3fff, "event");
        close_out();
    end
endmodule
`default_nettype wire

// ===== hdl/status_filter.sv
// status_filter: condition register, transition filters, event and enable registers
// of one status register group, with its summary bit.
// assumes condition and transient inputs are asynchronous pins; commands are same-clock.
`timescale 1ns/100ps
`default_nettype none

module status_filter
    import status_filter_pkg::*;
#(
    parameter logic [15:0] IMPL_MASK = 16'hffff,
    parameter logic [15:0] USED_MASK = 16'hffff
)
(
    // clock and reset
    input  wire logic  CLK,
    input  wire logic  RSTN,
    // monitored instrument states
    input  wire logic [REG_W-1:0] COND_IN,
    input  wire logic [REG_W-1:0] TRANSIENT_IN,
    // status command port
    input  wire logic  CMD_VALID,
    input  wire cmd_t  CMD,
    // query answer and summary
    output var  resp_t RESP,
    output logic       SUMMARY
);

    logic [REG_W-1:0] cond_meta_ff, cond_ff, cond_prev_ff;
    logic [REG_W-1:0] trans_meta_ff, trans_sync_ff, trans_prev_ff;
    logic [REG_W-1:0] rise_mask_ff, fall_mask_ff, enable_ff, event_ff;
    logic [REG_W-1:0] nxt_rise_mask, nxt_fall_mask, nxt_enable, nxt_event;
    logic [REG_W-1:0] rise, fall, rise_hit, fall_hit, trans_hit, clr;
    resp_t            resp_ff, nxt_resp;
    logic             summary_ff, nxt_summary;
    logic             cmd_rst, cmd_cls, cmd_qev;

    // input synchronisers; first stage only feeds the second
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            cond_meta_ff  <= ZERO_WORD;
            cond_ff       <= ZERO_WORD;
            cond_prev_ff  <= ZERO_WORD;
            trans_meta_ff <= ZERO_WORD;
            trans_sync_ff <= ZERO_WORD;
            trans_prev_ff <= ZERO_WORD;
        end
        else
        begin
            cond_meta_ff  <= COND_IN;
            cond_ff       <= cond_meta_ff & IMPL_MASK & USED_MASK;
            cond_prev_ff  <= cond_ff;
            trans_meta_ff <= TRANSIENT_IN;
            trans_sync_ff <= trans_meta_ff;
            trans_prev_ff <= trans_sync_ff;
        end
    end

    // edge detection per bit; a held transient level counts once
    genvar gi;
    generate
        for (gi = 0; gi < REG_W; gi++)
        begin : g_bit
            assign rise[gi]      = cond_ff[gi] & ~cond_prev_ff[gi];
            assign fall[gi]      = ~cond_ff[gi] & cond_prev_ff[gi];
            assign rise_hit[gi]  = rise[gi] & rise_mask_ff[gi];
            assign fall_hit[gi]  = fall[gi] & fall_mask_ff[gi];
            assign trans_hit[gi] = trans_sync_ff[gi] & ~trans_prev_ff[gi]
                                   & ~IMPL_MASK[gi] & USED_MASK[gi];
        end
    endgenerate

    assign cmd_rst = CMD_VALID && CMD.op == OP_RESET_CMD;
    assign cmd_cls = CMD_VALID && CMD.op == OP_CLEAR_STATUS;
    assign cmd_qev = CMD_VALID && CMD.op == OP_READ_EVENT;
    assign clr     = (cmd_cls || cmd_qev) ? USED_MASK : ZERO_WORD;

    always_comb
    begin
        nxt_rise_mask = rise_mask_ff;
        nxt_fall_mask = fall_mask_ff;
        nxt_enable    = enable_ff;
        nxt_resp      = '{valid: 1'b0, data: ZERO_WORD};
        // set wins over clear so nothing is lost to a query
        nxt_event     = (event_ff & ~clr) | rise_hit | fall_hit | trans_hit;
        if (CMD_VALID)
        begin
            case (CMD.op)
                OP_READ_COND:    nxt_resp = '{valid: 1'b1, data: cond_ff};
                OP_READ_EVENT:   nxt_resp = '{valid: 1'b1, data: event_ff};
                OP_READ_RISE:    nxt_resp = '{valid: 1'b1, data: rise_mask_ff};
                OP_READ_FALL:    nxt_resp = '{valid: 1'b1, data: fall_mask_ff};
                OP_READ_ENABLE:  nxt_resp = '{valid: 1'b1, data: enable_ff};
                OP_WRITE_RISE:   nxt_rise_mask = CMD.data;
                OP_WRITE_FALL:   nxt_fall_mask = CMD.data;
                OP_WRITE_ENABLE: nxt_enable = CMD.data & USED_MASK;
                OP_RESET_CMD:
                begin
                    nxt_rise_mask = RISE_MASK_RST;
                    nxt_fall_mask = FALL_MASK_RST;
                end
                default:         nxt_resp = '{valid: 1'b0, data: ZERO_WORD};
            endcase
        end
        // summary from next values so it never lags the event register
        nxt_summary = |(nxt_event & nxt_enable);
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rise_mask_ff <= RISE_MASK_RST;
            fall_mask_ff <= FALL_MASK_RST;
            enable_ff    <= ENABLE_RST;
            event_ff     <= EVENT_RST;
            resp_ff      <= '{valid: 1'b0, data: ZERO_WORD};
            summary_ff   <= 1'b0;
        end
        else
        begin
            rise_mask_ff <= nxt_rise_mask;
            fall_mask_ff <= nxt_fall_mask;
            enable_ff    <= nxt_enable;
            event_ff     <= nxt_event;
            resp_ff      <= nxt_resp;
            summary_ff   <= nxt_summary;
        end
    end

    assign RESP    = resp_ff;
    assign SUMMARY = summary_ff;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    a_cond_tracks: assert property (
        ##3 cond_ff == ($past(COND_IN, 2) & IMPL_MASK & USED_MASK))
        else $error("condition register does not track its input");
    a_cond_readback: assert property (
        CMD_VALID && CMD.op == OP_READ_COND |=> RESP.valid && RESP.data == $past(cond_ff)
            && (RESP.data & ~USED_MASK) == ZERO_WORD)
        else $error("condition read returned wrong word");
    a_rise_latches: assert property (
        rise_hit != ZERO_WORD |=> (event_ff & $past(rise_hit)) == $past(rise_hit))
        else $error("passed rising edge not latched");
    a_fall_latches: assert property (
        fall_hit != ZERO_WORD |=> (event_ff & $past(fall_hit)) == $past(fall_hit))
        else $error("passed falling edge not latched");
    a_event_cause: assert property (
        ##1 (event_ff & ~$past(event_ff)
             & ~$past(rise_hit | fall_hit | trans_hit)) == ZERO_WORD)
        else $error("event bit set without a passed transition");
    a_event_holds: assert property (
        !cmd_cls && !cmd_qev |=> (event_ff & $past(event_ff)) == $past(event_ff))
        else $error("event bit dropped without a clear");
    a_masks_keep: assert property (
        CMD_VALID && (CMD.op == OP_CLEAR_STATUS || CMD.op == OP_READ_EVENT)
        |=> $stable(rise_mask_ff) && $stable(fall_mask_ff) && $stable(enable_ff))
        else $error("mask or enable changed by clear or query");
    a_reset_cmd: assert property (
        cmd_rst |=> rise_mask_ff == RISE_MASK_RST ##0 fall_mask_ff == FALL_MASK_RST)
        else $error("reset command did not restore filters");
    a_summary_or: assert property (
        SUMMARY == |(event_ff & enable_ff))
        else $error("summary bit disagrees with event and enable");

    // a passed edge in the clearing cycle must survive the clear
    a_set_wins: assert property (
        (cmd_cls || cmd_qev) && (rise_hit | fall_hit | trans_hit) != ZERO_WORD
        |=> (event_ff & $past(rise_hit | fall_hit | trans_hit)) == $past(rise_hit | fall_hit | trans_hit))
        else $error("edge lost to a simultaneous clear");

    a_clear_event: assert property (
        cmd_cls && (rise_hit | fall_hit | trans_hit) == ZERO_WORD |=> event_ff == ZERO_WORD)
        else $error("clear-status left event bits set");

    // filter writes land in the cycle right after the taking edge
    a_write_rise: assert property (
        CMD_VALID && CMD.op == OP_WRITE_RISE |=> rise_mask_ff == $past(CMD.data))
        else $error("rising mask write did not land");

    a_write_fall: assert property (
        CMD_VALID && CMD.op == OP_WRITE_FALL |=> fall_mask_ff == $past(CMD.data))
        else $error("falling mask write did not land");

    // unused enable positions must drop written ones
    a_write_enable: assert property (
        CMD_VALID && CMD.op == OP_WRITE_ENABLE |=> enable_ff == ($past(CMD.data) & USED_MASK))
        else $error("enable write did not land");

    a_unused_zero: assert property (
        (event_ff & ~USED_MASK) == ZERO_WORD && (enable_ff & ~USED_MASK) == ZERO_WORD)
        else $error("unused position holds a one");

    // transient positions never show in the condition register
    a_no_cond_bit: assert property (
        (cond_ff & ~IMPL_MASK) == ZERO_WORD)
        else $error("condition bit on a transient position");

    // blocked edges on clear bits must leave them clear
    a_rise_blocked: assert property (
        (rise & ~rise_mask_ff & ~event_ff) != ZERO_WORD
        |=> (event_ff & $past(rise & ~rise_mask_ff & ~event_ff)) == ZERO_WORD)
        else $error("blocked rising edge set an event bit");

    a_fall_blocked: assert property (
        (fall & ~fall_mask_ff & ~event_ff) != ZERO_WORD
        |=> (event_ff & $past(fall & ~fall_mask_ff & ~event_ff)) == ZERO_WORD)
        else $error("blocked falling edge set an event bit");

    // reset command only touches the two filters
    a_reset_keeps: assert property (
        cmd_rst |=> $stable(enable_ff))
        else $error("reset command changed the enable register");

endmodule

`default_nettype wire

// ===== include/status_filter_pkg.sv
// status_filter_pkg: constants and carrier types of the status condition group.
// assumes one 125 MHz clock and a command port driven by the remote-command parser.
//
// Overview of operation
// - condition bits track monitored states each cycle, no latching of past values.
// - condition register is 16 bits, read-only; unused positions read zero.
// - transient states bypass condition and filters, setting event bits directly.
// - a 0 to 1 change between consecutive samples is a rising transition.
// - a 1 to 0 change between consecutive samples is a falling transition.
// - two 16-bit filter registers: rising-edge mask and falling-edge mask.
// - rising transition sets event bit only when its rising-edge mask bit is 1.
// - falling transition sets event bit only when its falling-edge mask bit is 1.
// - both mask bits 1 pass either edge; both 0 pass none.
// - both masks read-write, kept through clear-status and queries.
// - power-on and reset command: rising mask all ones, falling mask all zeros.
// - event bits latch until event query or clear-status; more edges add nothing.
// - summary bit is OR over positions of event AND enable.
// - enable register read-write, unused positions ignored, kept through clears and queries.
package status_filter_pkg;

    localparam int          REG_W         = 16;
    localparam logic [15:0] RISE_MASK_RST = 16'hffff;
    localparam logic [15:0] FALL_MASK_RST = 16'h0000;
    localparam logic [15:0] ENABLE_RST    = 16'h0000;
    localparam logic [15:0] EVENT_RST     = 16'h0000;
    localparam logic [15:0] ZERO_WORD     = 16'h0000;

    // one status command per valid cycle
    typedef enum logic [3:0] {
        OP_READ_COND,
        OP_READ_EVENT,
        OP_READ_RISE,
        OP_WRITE_RISE,
        OP_READ_FALL,
        OP_WRITE_FALL,
        OP_READ_ENABLE,
        OP_WRITE_ENABLE,
        OP_CLEAR_STATUS,
        OP_RESET_CMD
    } cmd_op_t;

    typedef struct packed {
        cmd_op_t     op;
        logic [15:0] data;
    } cmd_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } resp_t;

endpackage
